// >>> sdc_regs.svh
/*
 * register offsets, field positions and reset values of the divider
 * configuration loader.
 * assumes: byte addresses on a 12-bit apb address, 32-bit data.
 */
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// register byte offsets
`define SDC_CFG_OFS 12'h000
`define SDC_DIV_OFS 12'h004
`define SDC_SHIFT_OFS 12'h008
`define SDC_CTRL_OFS 12'h00c
`define SDC_EVENT_OFS 12'h010

// serial stream layout, first bit shifted ends up at the top
`define SDC_SR_LEN 14
`define SDC_T_MSB 13
`define SDC_T_LSB 11
`define SDC_N_MSB 10
`define SDC_N_LSB 9
`define SDC_M_MSB 6

// control bits
`define SDC_CTRL_SER_EN 0
`define SDC_CTRL_TICK_EN 1

// event bits
`define SDC_EV_PAR_CAP 0
`define SDC_EV_SER_COMMIT 1
`define SDC_EV_SER_REFUSED 2

// reset values: pins pulled high, parallel strobe held low
`define SDC_PIN_RST 10'h1ff
`define SDC_CFG_RST 12'h1ff
`define SDC_CTRL_RST 2'h3

// advisory loop modulus window for a 16 MHz reference
`define SDC_M_MIN 7'h19
`define SDC_M_MAX 7'h32

`endif

// >>> sdc_pkg.sv
/*
 * types shared by the divider configuration loader.
 * assumes: nothing beyond a sv compiler.
 */
package sdc_pkg;

    // divider configuration as held in the counters
    typedef struct packed {
        logic [2:0] test;
        logic [1:0] odiv;
        logic [6:0] mod;
    } sdc_cfg_t;

endpackage : sdc_pkg

// >>> sdc_ser_if.sv
/*
 * carrier between the serial shifter and the loader core.
 * assumes: both ends run on core_clk.
 */
`timescale 1ns/10ps
interface sdc_ser_if #(parameter int SR_LEN = 14);
    logic [SR_LEN-1:0] shift;
    logic [4:0] bit_cnt;
    logic commit;

    modport sh (output shift, output bit_cnt, output commit);
    modport core (input shift, input bit_cnt, input commit);
endinterface : sdc_ser_if

// >>> sdc_ser_shift.sv
/*
 * serial three-wire shifter: samples the serial pins, shifts on each
 * serial clock rise, flags a commit on each serial load fall.
 * assumes: pins are asynchronous to core_clk and far slower than it.
 */
`timescale 1ns/10ps
`include "sdc_regs.svh"
module sdc_ser_shift #(
    parameter int SR_LEN = `SDC_SR_LEN
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_load,
    // towards the core
    sdc_ser_if.sh ser
);
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] pin;
    logic [2:0] pin_prev;
    logic clk_rise;

    // three-stage sampling; a level counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
            pin <= 3'h0;
            pin_prev <= 3'h0;
        end else begin
            s1 <= {ser_load, ser_data, ser_clk};
            s2 <= s1;
            s3 <= s2;
            pin <= (s3 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
            pin_prev <= pin;
        end
    end

    // data and clock share one pipeline, so setup at the pins is kept
    assign clk_rise = pin[0] & ~pin_prev[0];
    assign ser.commit = pin_prev[2] & ~pin[2];

    // shift on each serial clock rise, msb of each field first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ser.shift <= '0;
        end else if (clk_rise) begin
            ser.shift <= {ser.shift[SR_LEN-2:0], pin[1]};
        end
    end

    // bits seen since the last commit, saturating
    always_ff @(posedge core_clk) begin
        if (rst || ser.commit) begin
            ser.bit_cnt <= 5'h00;
        end else if (clk_rise && ser.bit_cnt != 5'h1f) begin
            ser.bit_cnt <= 5'(ser.bit_cnt + 5'h01);
        end
    end

    property p_shift_step;
        @(posedge core_clk) disable iff (rst)
        clk_rise |=> ser.shift == {$past(ser.shift[SR_LEN-2:0]), $past(pin[1])};
    endproperty
    a_shift_step: assert property (p_shift_step) else $error("shift missed a bit");

    property p_shift_hold;
        @(posedge core_clk) disable iff (rst)
        !clk_rise |=> $stable(ser.shift);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift moved without clock");

endmodule : sdc_ser_shift

// >>> sdc_config_loader.sv
/*
 * divider configuration loader of a pll clock synthesizer: parallel
 * pins with a load strobe, serial shifter with a commit strobe, apb
 * status and control registers, and an output divider tick.
 * assumes: all pins are asynchronous to core_clk (100 MHz); the apb
 * master runs on core_clk; reset is synchronous and active high.
 */
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "sdc_regs.svh"
module sdc_config_loader (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // parallel configuration pins
    input wire logic par_load_n,
    input wire logic [6:0] loop_mod_pin,
    input wire logic [1:0] out_div_pin,
    // serial configuration pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_load,
    // divider configuration
    output logic [6:0] loop_mod,
    output logic [1:0] out_div_sel,
    output logic [2:0] test_sel,
    output logic [3:0] out_div_ratio,
    output logic [7:0] fb_div,
    output logic out_tick
);
    logic [9:0] par_s1;
    logic [9:0] par_s2;
    logic [9:0] par_s3;
    logic [9:0] par_pin;
    logic pload_prev;
    logic pload_hi;
    logic pload_rise;
    sdc_pkg::sdc_cfg_t cfg;
    logic commit_ok;
    logic commit_refused;
    logic ser_en;
    logic tick_en;
    logic [2:0] ev;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic [3:0] div_cnt;
    logic m_ok;
    logic hit;
    logic wr;

    sdc_ser_if #(.SR_LEN(`SDC_SR_LEN)) ser ();

    // divider select decode, shared by the ratio register and the tick
    function automatic logic [3:0] odiv_ratio(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h1;
        case (sel)
            2'b11: r = 4'h1;
            2'b00: r = 4'h2;
            2'b01: r = 4'h4;
            2'b10: r = 4'h8;
            default: r = 4'h1;
        endcase
        return r;
    endfunction : odiv_ratio

    // serial shifter lives in its own module
    sdc_ser_shift #(.SR_LEN(`SDC_SR_LEN)) u_shift (
        .core_clk(core_clk),
        .rst(rst),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_load(ser_load),
        .ser(ser.sh)
    );

    // three-stage sampling of strobe and parallel pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            par_s1 <= `SDC_PIN_RST;
            par_s2 <= `SDC_PIN_RST;
            par_s3 <= `SDC_PIN_RST;
            par_pin <= `SDC_PIN_RST;
        end else begin
            par_s1 <= {par_load_n, out_div_pin, loop_mod_pin};
            par_s2 <= par_s1;
            par_s3 <= par_s2;
            par_pin <= (par_s3 & ~(par_s2 ^ par_s3)) | (par_pin & (par_s2 ^ par_s3));
        end
    end

    // strobe edge, seen on the filtered level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pload_prev <= 1'b0;
        end else begin
            pload_prev <= par_pin[9];
        end
    end

    assign pload_hi = par_pin[9];
    assign pload_rise = pload_hi & ~pload_prev;

    // serial commit only with the parallel strobe high and no capture now
    assign commit_ok = ser.commit & pload_hi & ~pload_rise & ser_en;
    assign commit_refused = ser.commit & ~commit_ok;

    // counter load: parallel transparent, parallel capture, then serial
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg <= `SDC_CFG_RST;
        end else if (!pload_hi) begin
            cfg.test <= 3'h0;
            cfg.odiv <= par_pin[8:7];
            cfg.mod <= par_pin[6:0];
        end else if (pload_rise) begin
            cfg.odiv <= par_pin[8:7];
            cfg.mod <= par_pin[6:0];
        end else if (commit_ok) begin
            cfg.test <= ser.shift[`SDC_T_MSB:`SDC_T_LSB];
            cfg.odiv <= ser.shift[`SDC_N_MSB:`SDC_N_LSB];
            cfg.mod <= ser.shift[`SDC_M_MSB:0];
        end
    end

    assign loop_mod = cfg.mod;
    assign out_div_sel = cfg.odiv;
    assign test_sel = cfg.test;

    // derived divide figures; feedback runs at twice the modulus
    // because the reference is halved before the phase compare
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_div_ratio <= 4'h1;
            fb_div <= 8'h00;
            m_ok <= 1'b0;
        end else begin
            out_div_ratio <= odiv_ratio(cfg.odiv);
            fb_div <= {cfg.mod, 1'b0};
            m_ok <= (cfg.mod >= `SDC_M_MIN) && (cfg.mod <= `SDC_M_MAX);
        end
    end

    // output divider as a clock enable on the core clock
    always_ff @(posedge core_clk) begin
        if (rst || !tick_en) begin
            div_cnt <= 4'h0;
            out_tick <= 1'b0;
        end else if (div_cnt >= 4'(odiv_ratio(cfg.odiv) - 4'h1)) begin
            div_cnt <= 4'h0;
            out_tick <= 1'b1;
        end else begin
            div_cnt <= 4'(div_cnt + 4'h1);
            out_tick <= 1'b0;
        end
    end

    // apb decode; zero wait states, unmapped answers with an error
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign hit = (paddr == `SDC_CFG_OFS) || (paddr == `SDC_DIV_OFS) ||
        (paddr == `SDC_SHIFT_OFS) || (paddr == `SDC_CTRL_OFS) ||
        (paddr == `SDC_EVENT_OFS);
    assign pslverr = psel & penable & ~hit;

    // read data registered in the setup phase, ready in the access phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `SDC_CFG_OFS) begin
                prdata <= {14'h0, m_ok, pload_hi, 1'b0, cfg.test, 2'h0, cfg.odiv,
                    1'b0, cfg.mod};
            end else if (paddr == `SDC_DIV_OFS) begin
                prdata <= {16'h0, fb_div, 4'h0, out_div_ratio};
            end else if (paddr == `SDC_SHIFT_OFS) begin
                prdata <= {11'h0, ser.bit_cnt, 2'h0, ser.shift};
            end else if (paddr == `SDC_CTRL_OFS) begin
                prdata <= {30'h0, tick_en, ser_en};
            end else if (paddr == `SDC_EVENT_OFS) begin
                prdata <= {29'h0, ev};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // control register; serial gate lets software hold the counters against serial commits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {tick_en, ser_en} <= `SDC_CTRL_RST;
        end else if (wr && pstrb[0] && paddr == `SDC_CTRL_OFS) begin
            ser_en <= pwdata[`SDC_CTRL_SER_EN];
            tick_en <= pwdata[`SDC_CTRL_TICK_EN];
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    assign ev_set = {commit_refused, commit_ok, pload_rise};
    assign ev_clr = (wr && pstrb[0] && paddr == `SDC_EVENT_OFS) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ev <= 3'h0;
        end else begin
            ev <= (ev & ~ev_clr) | ev_set;
        end
    end

    property p_div8;
        @(posedge core_clk) disable iff (rst)
        (out_div_sel == 2'b10 && $past(out_div_sel) == 2'b10) |-> out_div_ratio == 4'h8;
    endproperty
    a_div8: assert property (p_div8) else $error("select 10 not divide by 8");

    property p_div1;
        @(posedge core_clk) disable iff (rst)
        (out_div_sel == 2'b11 && $past(out_div_sel) == 2'b11) |-> out_div_ratio == 4'h1;
    endproperty
    a_div1: assert property (p_div1) else $error("select 11 not divide by 1");

    // the figure lags reset by one edge, so skip the edge right after it
    property p_fb;
        @(posedge core_clk) disable iff (rst)
        (!$past(rst) && $stable(loop_mod)) |-> fb_div == {loop_mod, 1'b0};
    endproperty
    a_fb: assert property (p_fb) else $error("feedback not twice modulus");

    property p_par_capture;
        @(posedge core_clk) disable iff (rst)
        pload_rise |=> loop_mod == $past(par_pin[6:0]) && out_div_sel == $past(par_pin[8:7]);
    endproperty
    a_par_capture: assert property (p_par_capture) else $error("capture missed");

    property p_transparent;
        @(posedge core_clk) disable iff (rst)
        !pload_hi |=> loop_mod == $past(par_pin[6:0]) && out_div_sel == $past(par_pin[8:7]);
    endproperty
    a_transparent: assert property (p_transparent) else $error("not transparent");

    property p_test_zero;
        @(posedge core_clk) disable iff (rst)
        !pload_hi |=> test_sel == 3'h0;
    endproperty
    a_test_zero: assert property (p_test_zero) else $error("test select not forced");

    property p_ser_commit;
        @(posedge core_clk) disable iff (rst)
        commit_ok |=> test_sel == $past(ser.shift[13:11]) &&
            out_div_sel == $past(ser.shift[10:9]) && loop_mod == $past(ser.shift[6:0]);
    endproperty
    a_ser_commit: assert property (p_ser_commit) else $error("serial commit wrong");

    property p_par_first;
        @(posedge core_clk) disable iff (rst)
        (pload_rise && ser.commit) |=> loop_mod == $past(par_pin[6:0]);
    endproperty
    a_par_first: assert property (p_par_first) else $error("serial beat parallel");

    property p_test_hold;
        @(posedge core_clk) disable iff (rst)
        (pload_hi && !ser.commit) |=> test_sel == $past(test_sel);
    endproperty
    a_test_hold: assert property (p_test_hold) else $error("test select moved");

    property p_div2;
        @(posedge core_clk) disable iff (rst)
        (out_div_sel == 2'b00 && $past(out_div_sel) == 2'b00) |-> out_div_ratio == 4'h2;
    endproperty
    a_div2: assert property (p_div2) else $error("select 00 not divide by 2");

    property p_div4;
        @(posedge core_clk) disable iff (rst)
        (out_div_sel == 2'b01 && $past(out_div_sel) == 2'b01) |-> out_div_ratio == 4'h4;
    endproperty
    a_div4: assert property (p_div4) else $error("select 01 not divide by 4");

    // an applied commit must always leave its event behind
    property p_commit_event;
        @(posedge core_clk) disable iff (rst)
        commit_ok |=> ev[`SDC_EV_SER_COMMIT];
    endproperty
    a_commit_event: assert property (p_commit_event) else $error("commit event lost");

    // a refused commit with the strobe high and no capture leaves the counters alone
    property p_refused_hold;
        @(posedge core_clk) disable iff (rst)
        (commit_refused && pload_hi && !pload_rise) |=> $stable(loop_mod) && $stable(test_sel);
    endproperty
    a_refused_hold: assert property (p_refused_hold) else $error("refused commit applied");

    property p_m_window;
        @(posedge core_clk) disable iff (rst)
        !$past(rst) |-> m_ok == ($past(cfg.mod) >= `SDC_M_MIN && $past(cfg.mod) <= `SDC_M_MAX);
    endproperty
    a_m_window: assert property (p_m_window) else $error("modulus window flag wrong");

endmodule : sdc_config_loader

// >>> sdc_ctrl_model.sv
/*
 * model of the board controller on the serial configuration pins.
 * assumes: the bench calls send() and keeps the parallel strobe high
 * whenever a commit is meant to land.
 */
`timescale 1ns/10ps
module sdc_ctrl_model (
    // serial pins
    output logic ser_clk,
    output logic ser_data,
    output logic ser_load
);
    // link clock stands low outside frames
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b0;
    end

    // one frame, top bit first; half sets the link rate
    task automatic send(input logic [13:0] w, input int half);
        for (int i = 13; i >= 0; i--) begin
            ser_data = w[i];
            #half;
            ser_clk = 1'b1;
            #half;
            ser_clk = 1'b0;
        end
        // released data line must not keep the last bit
        ser_data = ~ser_data;
        #half;
        ser_load = 1'b1; // commit only after the full frame
        #half;
        ser_load = 1'b0;
        #half;
    endtask : send
endmodule : sdc_ctrl_model

// >>> tb_sdc_config_loader.sv
/*
 * self-checking bench of the divider configuration loader.
 * assumes: apb at 0 wait states or more, pins filtered in a few edges.
 */
`timescale 1ns/10ps
`include "sdc_regs.svh"
module tb_sdc_config_loader;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic par_load_n = 1'b0;
    logic [6:0] loop_mod_pin = 7'h7f;
    logic [1:0] out_div_pin = 2'h3;
    wire logic ser_clk, ser_data, ser_load;
    logic [31:0] prdata;
    logic pready, pslverr, out_tick;
    logic [6:0] loop_mod;
    logic [1:0] out_div_sel;
    logic [2:0] test_sel;
    logic [3:0] out_div_ratio;
    logic [7:0] fb_div;
    int fail_count = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h0000_001f;
    logic [31:0] rd;
    logic er;
    logic [13:0] w;
    sdc_pkg::sdc_cfg_t c;

    sdc_config_loader sdc_config_loader_inst (.core_clk(core_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .par_load_n(par_load_n),
        .loop_mod_pin(loop_mod_pin), .out_div_pin(out_div_pin), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_load(ser_load), .loop_mod(loop_mod),
        .out_div_sel(out_div_sel), .test_sel(test_sel), .out_div_ratio(out_div_ratio),
        .fb_div(fb_div), .out_tick(out_tick));
    sdc_ctrl_model sdc_ctrl_model_inst (.ser_clk(ser_clk), .ser_data(ser_data),
        .ser_load(ser_load));

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // divide ratio expected from the select code
    function automatic int ratio(input logic [1:0] s);
        case (s)
            2'b11: return 1;
            2'b00: return 2;
            2'b01: return 4;
            default: return 8;
        endcase
    endfunction : ratio

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        chk(n < 20, 1, "apb answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // wait, bounded, for the configuration, then compare everything
    task automatic settle(input sdc_pkg::sdc_cfg_t e);
        int n;
        n = 0;
        while ({test_sel, out_div_sel, loop_mod} !== e && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        repeat (2) @(negedge core_clk);
        chk({test_sel, out_div_sel, loop_mod}, e, "config");
        chk(out_div_ratio, ratio(e.odiv), "ratio");
        chk(fb_div, {e.mod, 1'b0}, "feedback");
    endtask : settle

    task automatic ticks(input int r);
        int n;
        n = 0;
        repeat (64) begin
            @(negedge core_clk);
            n += (out_tick === 1'b1);
        end
        chk(n, 64 / r, "tick count");
    endtask : ticks

    // watchdog, far beyond the roughly ten microseconds the run needs
    initial begin
        #500_000;
        fail_count++;
        $display("unexpected at %0t: watchdog", $time);
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        settle({3'h0, 2'h3, 7'h7f});
        apb(`SDC_CTRL_OFS, 1'b0, 0);
        chk(rd, `SDC_CTRL_RST, "ctrl reset");
        apb(12'h014, 1'b1, 32'hffff_ffff);
        chk(er, 1, "unmapped write");
        apb(12'h014, 1'b0, 0);
        chk({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
        $display("test reset done");
        // strobe low: counters follow pins for every divider code
        for (int k = 0; k < 4; k++) begin
            rd = rnd();
            c = {3'h0, 2'(k), rd[6:0]};
            @(posedge core_clk);
            loop_mod_pin <= c.mod;
            out_div_pin <= c.odiv;
            settle(c);
            ticks(ratio(c.odiv));
        end
        $display("test transparent done");
        // strobe rise captures, later pin changes are ignored
        @(posedge core_clk);
        par_load_n <= 1'b1;
        repeat (12) @(posedge core_clk);
        loop_mod_pin <= ~c.mod;
        out_div_pin <= ~c.odiv;
        repeat (12) @(negedge core_clk);
        chk({test_sel, out_div_sel, loop_mod}, c, "held");
        apb(`SDC_EVENT_OFS, 1'b0, 0);
        chk(rd[0], 1, "capture event");
        $display("test capture done");
        // serial frames after the parallel load, 80 ns link period
        for (int k = 0; k < 3; k++) begin
            rd = rnd();
            w = rd[13:0];
            sdc_ctrl_model_inst.send(w, 40);
            c = {w[13:11], w[10:9], w[6:0]};
            settle(c);
            apb(`SDC_SHIFT_OFS, 1'b0, 0);
            chk(rd[13:0], w, "shift");
            apb(`SDC_EVENT_OFS, 1'b0, 0);
            chk(rd[1], 1, "commit event");
            apb(`SDC_EVENT_OFS, 1'b1, 32'h0000_0002);
            apb(`SDC_EVENT_OFS, 1'b0, 0);
            chk(rd[1], 0, "commit cleared");
        end
        $display("test serial done");
        // commit disabled, and a read-only write
        apb(`SDC_CTRL_OFS, 1'b1, 32'h0000_0002);
        sdc_ctrl_model_inst.send(~w, 40);
        repeat (12) @(negedge core_clk);
        chk({test_sel, out_div_sel, loop_mod}, c, "refused");
        apb(`SDC_EVENT_OFS, 1'b0, 0);
        chk(rd[2], 1, "refused event");
        apb(`SDC_CFG_OFS, 1'b1, 32'h0000_0000);
        apb(`SDC_CFG_OFS, 1'b0, 0);
        chk(rd[6:0], c.mod, "cfg read-only");
        chk(rd[17], (c.mod >= `SDC_M_MIN && c.mod <= `SDC_M_MAX), "window");
        apb(`SDC_CTRL_OFS, 1'b1, 32'h0000_0003);
        $display("test disable done");
        // serial frame with strobe low: pins win, test bits stay zero;
        // pins pick divide by 2 to keep modulus 25 in range
        @(posedge core_clk);
        par_load_n <= 1'b0;
        loop_mod_pin <= 7'h19;
        out_div_pin <= 2'h0;
        sdc_ctrl_model_inst.send(14'h3fff, 40);
        settle({3'h0, 2'h0, 7'h19});
        $display("test priority done");
        end_of_test();
    end
endmodule : tb_sdc_config_loader
